//--- logic/gcts_pkg.sv
package gcts_pkg;

    // ------------------------------------------------------------
    // Register offsets (internal 7-bit addresses)
    // ------------------------------------------------------------
    localparam logic [6:0] GCTS_ADDR_SUMMARY    = 7'h1F; // Summary read, command write
    localparam logic [6:0] GCTS_ADDR_SYNC_CTRL  = 7'h20; // Transmit sync control
    localparam logic [6:0] GCTS_ADDR_DELAY_LOW  = 7'h21; // Sync delay low byte
    localparam logic [6:0] GCTS_ADDR_DELAY_HIGH = 7'h22; // Sync delay high byte

    // ------------------------------------------------------------
    // Broadcast command codes
    // ------------------------------------------------------------
    localparam logic [7:0] GCTS_CMD_EXT_ON   = 8'hCE; // Extended addressing on
    localparam logic [7:0] GCTS_CMD_EXT_OFF  = 8'hCD; // Extended addressing off
    localparam logic [3:0] GCTS_CMD_TRIG_HI  = 4'hE;  // Upper nibble of trigger codes

    // ------------------------------------------------------------
    // SPI command byte layout and address forming
    // ------------------------------------------------------------
    localparam int         GCTS_CMD_WRITE_BIT = 7;     // Write/read flag
    localparam int         GCTS_CMD_UART_BIT  = 5;     // UART select
    localparam logic [2:0] GCTS_STD_PREFIX    = 3'h0;  // Standard upper bits
    localparam logic [2:0] GCTS_EXT_PREFIX    = 3'h2;  // Extended upper bits

    // ------------------------------------------------------------
    // Sync control field positions
    // ------------------------------------------------------------
    localparam int GCTS_CLK_PIN_BIT  = 7; // Clock to pin
    localparam int GCTS_AUTO_DIS_BIT = 6; // Auto transmitter disable
    localparam int GCTS_DELAY_BIT    = 5; // Delayed start enable
    localparam int GCTS_SYNC_EN_BIT  = 4; // Sync enable

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GCTS_CTRL_RESET    = 8'h00; // Sync control reset
    localparam logic [7:0] GCTS_DELAY_RESET   = 8'h00; // Delay bytes reset
    localparam logic [1:0] GCTS_SUMMARY_RESET = 2'h3;  // Pending bits idle high
    localparam logic [5:0] GCTS_SUMMARY_PAD   = 6'h00; // Upper summary bits

endpackage

//--- logic/gcts_sync_unit.sv
`timescale 1ns/1ps
`default_nettype none

module gcts_sync_unit
    import gcts_pkg::*;
#(
    parameter int DELAY_W = 16
)(
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         ctrl,
    input  wire logic [DELAY_W-1:0] delay,
    input  wire logic               trig_pulse,
    input  wire logic [3:0]         trig_num,
    input  wire logic               bit_tick,
    input  wire logic               queue_has_data,
    input  wire logic               queue_drained,
    output logic                    transmitter_off,
    output logic                    tx_start
);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        GCTS_IDLE  = 2'b00, // Waiting for trigger
        GCTS_WAIT  = 2'b01, // Counting delay
        GCTS_SEND  = 2'b10  // Transmitter released
    } gcts_state_e;

    gcts_state_e        state_reg;  // Current state
    logic [DELAY_W-1:0] count_reg;  // Bit intervals remaining

    wire logic sync_en  = ctrl[GCTS_SYNC_EN_BIT];
    wire logic hit      = sync_en && trig_pulse && (trig_num == ctrl[3:0]); // [RULE12] [RULE15]
    wire logic go       = hit && queue_has_data; // [RULE14]

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        tx_start <= 1'b0;
        if (!reset_n)
        begin
            state_reg <= GCTS_IDLE;
            count_reg <= '0;
        end
        else if (!sync_en)
        begin
            state_reg <= GCTS_IDLE; // [RULE15]
        end
        else
        begin
            unique case (state_reg)
                GCTS_IDLE:
                begin
                    if (go && ctrl[GCTS_DELAY_BIT] && delay != '0)
                    begin
                        state_reg <= GCTS_WAIT; // [RULE17] [RULE24]
                        count_reg <= delay;
                    end
                    else if (go)
                    begin
                        state_reg <= GCTS_SEND;
                        tx_start  <= 1'b1; // [RULE16]
                    end
                end
                GCTS_WAIT:
                begin
                    // Count bit intervals down
                    if (bit_tick)
                    begin
                        count_reg <= count_reg - 1'b1; // [RULE18]
                        if (count_reg == {{(DELAY_W-1){1'b0}}, 1'b1})
                        begin
                            state_reg <= GCTS_SEND;
                            tx_start  <= 1'b1; // [RULE16]
                        end
                    end
                end
                GCTS_SEND:
                begin
                    // Re-arm once queue empties in auto mode
                    if (ctrl[GCTS_AUTO_DIS_BIT] && queue_drained)
                        state_reg <= GCTS_IDLE; // [RULE19]
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmitter disable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            transmitter_off <= 1'b0;
        else
            transmitter_off <= sync_en && (state_reg != GCTS_SEND) && !go; // [RULE13]
    end

endmodule

`default_nettype wire

//--- logic/gcts_top.sv
// Operation
// [RULE1] Active-low pending bit per UART, reset high
// [RULE2] Only unmasked sources; shared interrupt pin
// [RULE3] Bit returns high after status read
// [RULE4] Summary readable at 0x1F and fast read
// [RULE5] Write to 0x1F broadcast to both UARTs
// [RULE6] Command 0xCE selects extended SPI addressing
// [RULE7] Command 0xCD restores standard SPI addressing
// [RULE8] I2C uses seven-bit address directly
// [RULE9] UART select kept in extended mode
// [RULE10] Codes 0xE0..0xEF are triggers 0..15
// [RULE11] Host broadcasts trigger command to start
// [RULE12] Four-bit trigger select picks matching command
// [RULE13] Sync enable forces transmitter disable high
// [RULE14] Start on trigger only with queued data
// [RULE15] Sync disabled: triggers never start transmitter
// [RULE16] Start bit falling edge marks start
// [RULE17] Delay bit adds programmed sync delay
// [RULE18] Sixteen-bit delay in bit intervals
// [RULE19] Auto disable once queue fully sent
// [RULE20] Clock-to-pin bit drives sysclk copy to GPIO
// [RULE21] Command byte: write flag, zero, select, address
// [RULE22] Fast read ignores UART select bit
// [RULE23] Unknown command bytes change nothing
// [RULE24] Trigger sampled and timed in UART clock domain
`timescale 1ns/1ps
`default_nettype none

module gcts_top
    import gcts_pkg::*;
#(
    parameter int NUM_UART = 2,  // UARTs served
    parameter int DELAY_W  = 16  // Delay counter width
)(
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                spi_mode,          // High: SPI, low: I2C
    input  wire logic                cmd_valid,         // Command byte strobe
    input  wire logic [7:0]          cmd_byte,          // SPI command byte
    input  wire logic [6:0]          i2c_addr,          // I2C register address
    input  wire logic                i2c_uart,          // I2C UART select
    input  wire logic                wr_valid,          // Data write strobe
    input  wire logic [7:0]          wr_data,           // Data write byte
    input  wire logic                rd_req,            // Data read strobe
    input  wire logic [NUM_UART-1:0] source_pending,    // Raw sources, per UART
    input  wire logic [NUM_UART-1:0] interrupt_enable_mask, // Unmasked sources
    input  wire logic [NUM_UART-1:0] status_read,       // Status register read pulse
    input  wire logic [NUM_UART-1:0] bit_tick,          // One per bit interval
    input  wire logic [NUM_UART-1:0] queue_has_data,    // Transmit queue non-empty
    input  wire logic [NUM_UART-1:0] queue_drained,     // Queue fully sent
    input  wire logic [NUM_UART-1:0] uart_sysclk,       // Per-UART clock level
    output logic [7:0]               rd_data,           // Read result
    output logic [6:0]               reg_addr,          // Decoded internal address
    output logic                     reg_uart,          // Decoded UART select
    output logic                     fast_summary_valid,// Summary on command byte
    output logic [1:0]               fast_summary,      // Pending bits for MISO
    output logic                     irq_n,             // Shared interrupt pin
    output logic [NUM_UART-1:0]      transmitter_off,   // Forced transmit disable
    output logic [NUM_UART-1:0]      tx_start,          // Start bit begins
    output logic [NUM_UART-1:0]      sysclk_to_pin,     // Clock copy to GPIO
    output logic [NUM_UART-1:0]      sysclk_to_pin_en   // GPIO driven by clock
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_trigger(input logic [7:0] b);
        is_trigger = (b[7:4] == GCTS_CMD_TRIG_HI); // [RULE10]
    endfunction

    logic                ext_mode_reg;             // Extended SPI addressing
    logic [NUM_UART-1:0] uart_pending_n_reg;       // Active-low summary
    logic [7:0]          ctrl_reg   [NUM_UART];    // Sync control per UART
    logic [7:0]          dly_lo_reg [NUM_UART];    // Delay low per UART
    logic [7:0]          dly_hi_reg [NUM_UART];    // Delay high per UART
    logic                trig_pulse_reg;           // One-cycle trigger
    logic [3:0]          trig_num_reg;             // Trigger number
    logic [NUM_UART-1:0] clk_meta_reg;             // Clock pin sync stage 1
    logic [NUM_UART-1:0] clk_sync_reg;             // Clock pin sync stage 2
    logic [NUM_UART-1:0] pend_hold_reg;            // Latched pending

    wire logic broadcast = wr_valid && (reg_addr == GCTS_ADDR_SUMMARY); // [RULE5]

    // ------------------------------------------------------------
    // Address forming from command byte or I2C address
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        fast_summary_valid <= 1'b0;
        if (!reset_n)
        begin
            reg_addr     <= 7'h00;
            reg_uart     <= 1'b0;
            fast_summary <= GCTS_SUMMARY_RESET;
        end
        else if (cmd_valid && spi_mode)
        begin
            reg_uart <= cmd_byte[GCTS_CMD_UART_BIT]; // [RULE21] [RULE9]
            if (ext_mode_reg)
                reg_addr <= {GCTS_EXT_PREFIX, cmd_byte[3:0]}; // [RULE6]
            else
                reg_addr <= {GCTS_STD_PREFIX[1:0], cmd_byte[4:0]}; // [RULE7]
            if (!cmd_byte[GCTS_CMD_WRITE_BIT])
            begin
                // Summary shifted during read command, select ignored
                fast_summary       <= uart_pending_n_reg[1:0]; // [RULE4] [RULE22]
                fast_summary_valid <= 1'b1;
            end
        end
        else if (cmd_valid)
        begin
            reg_addr <= i2c_addr; // [RULE8]
            reg_uart <= i2c_uart;
        end
        else if (wr_valid || rd_req)
        begin
            // Burst auto-increment past the queue address
            if (reg_addr != 7'h00)
                reg_addr <= reg_addr + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Broadcast command decode
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        trig_pulse_reg <= 1'b0;
        if (!reset_n)
        begin
            ext_mode_reg <= 1'b0;
            trig_num_reg <= 4'h0;
        end
        else if (broadcast)
        begin
            if (wr_data == GCTS_CMD_EXT_ON && spi_mode)
                ext_mode_reg <= 1'b1; // [RULE6]
            else if (wr_data == GCTS_CMD_EXT_OFF)
                ext_mode_reg <= 1'b0; // [RULE7]
            else if (is_trigger(wr_data))
            begin
                trig_pulse_reg <= 1'b1; // [RULE10] [RULE24]
                trig_num_reg   <= wr_data[3:0];
            end
            // Other codes fall through untouched [RULE23]
        end
    end

    // ------------------------------------------------------------
    // Pending summary; set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            pend_hold_reg <= '0;
        else
            pend_hold_reg <= (pend_hold_reg & ~status_read)
                           | (source_pending & interrupt_enable_mask); // [RULE2] [RULE3]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            uart_pending_n_reg <= '1; // [RULE1]
            irq_n              <= 1'b1;
        end
        else
        begin
            uart_pending_n_reg <= ~pend_hold_reg; // [RULE1]
            irq_n              <= ~|pend_hold_reg; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // Per-UART register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            for (int u = 0; u < NUM_UART; u++)
            begin
                ctrl_reg[u]   <= GCTS_CTRL_RESET;
                dly_lo_reg[u] <= GCTS_DELAY_RESET;
                dly_hi_reg[u] <= GCTS_DELAY_RESET;
            end
        end
        else if (wr_valid)
        begin
            unique case (reg_addr)
                GCTS_ADDR_SYNC_CTRL:  ctrl_reg[reg_uart]   <= wr_data;
                GCTS_ADDR_DELAY_LOW:  dly_lo_reg[reg_uart] <= wr_data; // [RULE18]
                GCTS_ADDR_DELAY_HIGH: dly_hi_reg[reg_uart] <= wr_data; // [RULE18]
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            rd_data <= 8'h00;
        else if (rd_req)
        begin
            unique case (reg_addr)
                GCTS_ADDR_SUMMARY:    rd_data <= {GCTS_SUMMARY_PAD, uart_pending_n_reg[1:0]}; // [RULE4]
                GCTS_ADDR_SYNC_CTRL:  rd_data <= ctrl_reg[reg_uart];
                GCTS_ADDR_DELAY_LOW:  rd_data <= dly_lo_reg[reg_uart];
                GCTS_ADDR_DELAY_HIGH: rd_data <= dly_hi_reg[reg_uart];
                default:              rd_data <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock copy to GPIO, synchronised
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            clk_meta_reg     <= '0;
            clk_sync_reg     <= '0;
            sysclk_to_pin    <= '0;
            sysclk_to_pin_en <= '0;
        end
        else
        begin
            clk_meta_reg <= uart_sysclk;
            clk_sync_reg <= clk_meta_reg;
            for (int u = 0; u < NUM_UART; u++)
            begin
                sysclk_to_pin_en[u] <= ctrl_reg[u][GCTS_CLK_PIN_BIT]; // [RULE20]
                sysclk_to_pin[u]    <= ctrl_reg[u][GCTS_CLK_PIN_BIT] & clk_sync_reg[u];
            end
        end
    end

    // ------------------------------------------------------------
    // Sync units, one per UART
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_UART; g++)
        begin : g_unit
            gcts_sync_unit #(
                .DELAY_W (DELAY_W)
            ) u_sync (
                .sys_clk         (sys_clk),
                .reset_n         (reset_n),
                .ctrl            (ctrl_reg[g]),
                .delay           (DELAY_W'({dly_hi_reg[g], dly_lo_reg[g]})),
                .trig_pulse      (trig_pulse_reg),
                .trig_num        (trig_num_reg),
                .bit_tick        (bit_tick[g]),
                .queue_has_data  (queue_has_data[g]),
                .queue_drained   (queue_drained[g]),
                .transmitter_off (transmitter_off[g]),
                .tx_start        (tx_start[g])
            );
        end
    endgenerate

endmodule

`default_nettype wire

//--- test/gcts_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host processor issuing register accesses
// ----------------------------------------
module gcts_host_model
(
    input  wire logic       sys_clk,   // Shared clock
    input  wire logic [7:0] rd_data,   // Read result
    output logic            spi_mode,  // Bus mode
    output logic            cmd_valid, // Command strobe
    output logic [7:0]      cmd_byte,  // SPI command byte
    output logic [6:0]      i2c_addr,  // I2C register address
    output logic            i2c_uart,  // I2C UART select
    output logic            wr_valid,  // Write strobe
    output logic [7:0]      wr_data,   // Write byte
    output logic            rd_req     // Read strobe
);
    // Quiet bus at time zero
    initial
    begin
        {spi_mode, cmd_valid, i2c_uart, wr_valid, rd_req} = 5'h10;
        {cmd_byte, wr_data, i2c_addr} = 23'h0;
    end
    // One command, one data byte, then the read result
    task automatic xfer(input logic s, input logic w, input logic u,
                        input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        spi_mode  <= s;
        cmd_valid <= 1'b1;
        cmd_byte  <= {w, 1'b0, u, a[4:0]};
        i2c_addr  <= a;
        i2c_uart  <= u;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_byte  <= ~{w, 1'b0, u, a[4:0]}; // Released lines carry junk
        wr_valid  <= w;
        rd_req    <= !w;
        wr_data   <= d;
        @(posedge sys_clk);
        wr_valid <= 1'b0;
        rd_req   <= 1'b0;
        wr_data  <= ~d;
        @(posedge sys_clk);
        q = rd_data;
    endtask
endmodule
`default_nettype wire

//--- test/gcts_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gcts_checker
    import gcts_pkg::*;
#(
    parameter int NUM_UART = 2 // UARTs served
)(
    input wire logic                sys_clk,
    input wire logic                reset_n,
    input wire logic                spi_mode,
    input wire logic                cmd_valid,
    input wire logic [7:0]          cmd_byte,
    input wire logic [6:0]          i2c_addr,
    input wire logic                i2c_uart,
    input wire logic                wr_valid,
    input wire logic [7:0]          wr_data,
    input wire logic [NUM_UART-1:0] source_pending,
    input wire logic [NUM_UART-1:0] interrupt_enable_mask,
    input wire logic [NUM_UART-1:0] status_read,
    input wire logic [6:0]          reg_addr,
    input wire logic                reg_uart,
    input wire logic                fast_summary_valid,
    input wire logic [1:0]          fast_summary,
    input wire logic                irq_n,
    input wire logic [NUM_UART-1:0] transmitter_off,
    input wire logic [NUM_UART-1:0] tx_start,
    input wire logic [NUM_UART-1:0] sysclk_to_pin_en
);
    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    logic [7:0] ctl0_reg; // UART0 sync control copy
    logic       ext_reg;  // Extended addressing copy
    // Follow host writes to control and command
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            ctl0_reg <= 8'h00;
            ext_reg  <= 1'b0;
        end
        else if (wr_valid && !cmd_valid && reg_addr == GCTS_ADDR_SYNC_CTRL && !reg_uart)
            ctl0_reg <= wr_data;
        else if (wr_valid && !cmd_valid && reg_addr == GCTS_ADDR_SUMMARY)
            ext_reg <= (wr_data == GCTS_CMD_EXT_ON && spi_mode) ? 1'b1 :
                       (wr_data == GCTS_CMD_EXT_OFF) ? 1'b0 : ext_reg;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    reset_values_a: assert property (disable iff (1'b0) !reset_n |=>
        irq_n && fast_summary == 2'h3 && tx_start == '0) else $error("bad reset state");
    irq_raise_a: assert property (((source_pending & interrupt_enable_mask) != '0) [*4]
        |-> !irq_n) else $error("pending source not flagged");
    irq_clear_a: assert property ((status_read == 2'h3 &&
        (source_pending & interrupt_enable_mask) == '0) ##1
        ((source_pending & interrupt_enable_mask) == '0) [*3] |-> irq_n) else $error("irq stuck");
    fast_read_a: assert property (cmd_valid && spi_mode && !cmd_byte[7]
        |=> fast_summary_valid) else $error("no fast summary");
    addr_std_a: assert property (cmd_valid && spi_mode && !ext_reg |=>
        reg_addr == {2'h0, $past(cmd_byte[4:0])}) else $error("bad standard address");
    addr_ext_a: assert property (cmd_valid && spi_mode && ext_reg |=>
        reg_addr == {GCTS_EXT_PREFIX, $past(cmd_byte[3:0])} && reg_uart == $past(cmd_byte[5]))
        else $error("bad extended address");
    addr_i2c_a: assert property (cmd_valid && !spi_mode |=> reg_addr == $past(i2c_addr)
        && reg_uart == $past(i2c_uart)) else $error("bad I2C address");
    sync_force_a: assert property ($rose(ctl0_reg[GCTS_SYNC_EN_BIT]) |->
        ##[0:2] transmitter_off[0]) else $error("transmitter not held off");
    start_sync_a: assert property (tx_start[0] |-> ctl0_reg[GCTS_SYNC_EN_BIT])
        else $error("start with sync off");
    start_pulse_a: assert property (tx_start[0] |=> !tx_start[0])
        else $error("start pulse too long");
    pin_enable_a: assert property (ctl0_reg[GCTS_CLK_PIN_BIT] |-> ##[0:2] sysclk_to_pin_en[0])
        else $error("clock not on pin");
endmodule
bind gcts_top gcts_checker #(.NUM_UART(NUM_UART)) u_gcts_checker (.*);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import gcts_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic       sys_clk = 1'b0, reg_uart, fast_summary_valid, irq_n;
    logic       reset_n = 1'b0;
    logic       spi_mode, cmd_valid, i2c_uart, wr_valid, rd_req;
    logic [7:0] cmd_byte, wr_data, rd_data;
    logic [6:0] i2c_addr, reg_addr;
    logic [1:0] source_pending = 2'h0, interrupt_enable_mask = 2'h0, status_read = 2'h0;
    logic [1:0] bit_tick = 2'h0, queue_has_data = 2'h0, queue_drained = 2'h0;
    logic [1:0] uart_sysclk = 2'h0, fs_last = 2'h0;
    logic [1:0] fast_summary, transmitter_off, tx_start, sysclk_to_pin, sysclk_to_pin_en;
    int         bad_count = 0, tests_run = 0, cyc = 0, n0 = 0, n1 = 0, fs_cnt = 0;
    always #5 sys_clk = ~sys_clk;
    gcts_top #(.NUM_UART(2), .DELAY_W(16)) u_gcts_top (.*);
    gcts_host_model u_gcts_host_model (.*);
    // Count starts and fast summaries, cut hangs short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        n0 <= n0 + int'(tx_start[0]);
        n1 <= n1 + int'(tx_start[1]);
        fs_cnt <= fs_cnt + int'(fast_summary_valid);
        if (fast_summary_valid)
            fs_last <= fast_summary;
        if (cyc == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic s, input logic u, input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_gcts_host_model.xfer(s, 1'b1, u, a, d, q);
    endtask
    task automatic rd(input logic s, input logic u, input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_gcts_host_model.xfer(s, 1'b0, u, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // Broadcast a trigger code
    task automatic trig(input logic [3:0] n);
        wr(1'b0, n[0], GCTS_ADDR_SUMMARY, {GCTS_CMD_TRIG_HI, n});
        wait_cyc(3);
    endtask
    task automatic give_verdict();
        $display("Checks run: %0d, mismatches: %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        wait_cyc(8);
        reset_n <= 1'b1;
        rd(1'b1, 1'b0, GCTS_ADDR_SUMMARY, 8'h03);
        chk({fs_cnt[5:0], fs_last}, 8'h07);
        for (int u = 0; u < 2; u++)
        begin
            rd(1'b0, u[0], GCTS_ADDR_SYNC_CTRL, GCTS_CTRL_RESET);
            rd(1'b0, u[0], GCTS_ADDR_DELAY_LOW, GCTS_DELAY_RESET);
            rd(1'b0, u[0], GCTS_ADDR_DELAY_HIGH, GCTS_DELAY_RESET);
        end
        // Masked and unmasked pending sources
        source_pending <= 2'h3;
        interrupt_enable_mask <= 2'h2;
        wait_cyc(4);
        chk({7'h0, irq_n}, 8'h00);
        rd(1'b0, 1'b0, GCTS_ADDR_SUMMARY, 8'h01);
        rd(1'b1, 1'b1, GCTS_ADDR_SUMMARY, 8'h01);
        chk({6'h0, fs_last}, 8'h01);
        source_pending <= 2'h0;
        wait_cyc(1);
        status_read <= 2'h3;
        wait_cyc(1);
        status_read <= 2'h0;
        wait_cyc(4);
        chk({7'h0, irq_n}, 8'h01);
        rd(1'b1, 1'b0, GCTS_ADDR_SUMMARY, 8'h03);
        // Control and delay set-up
        wr(1'b0, 1'b0, GCTS_ADDR_SYNC_CTRL, 8'h13);
        wr(1'b0, 1'b1, GCTS_ADDR_SYNC_CTRL, 8'h03);
        wr(1'b0, 1'b0, GCTS_ADDR_DELAY_LOW, 8'h02);
        wr(1'b0, 1'b0, GCTS_ADDR_DELAY_HIGH, 8'h01);
        chk({6'h0, transmitter_off}, 8'h01);
        // Extended map through SPI, unknown code ignored
        wr(1'b1, 1'b1, GCTS_ADDR_SUMMARY, GCTS_CMD_EXT_ON);
        wr(1'b0, 1'b0, GCTS_ADDR_SUMMARY, 8'h55);
        rd(1'b1, 1'b1, 7'h10, 8'h03);
        rd(1'b1, 1'b0, 7'h10, 8'h13);
        rd(1'b1, 1'b0, 7'h01, 8'h02);
        rd(1'b1, 1'b0, 7'h12, 8'h01);
        wr(1'b0, 1'b0, GCTS_ADDR_SUMMARY, GCTS_CMD_EXT_OFF);
        rd(1'b1, 1'b0, 7'h01, 8'h00);
        // Empty queue, then every code
        trig(4'h3);
        chk(n0[7:0], 8'h00);
        queue_has_data <= 2'h3;
        for (int n = 0; n < 16; n++)
        begin
            trig(n[3:0]);
            chk(n0[7:0], (n >= 3) ? 8'h01 : 8'h00);
            chk(n1[7:0], 8'h00);
        end
        // Auto disable after the queue drains
        wr(1'b0, 1'b0, GCTS_ADDR_SYNC_CTRL, 8'h53);
        trig(4'h3);
        chk({n0[6:0], transmitter_off[0]}, 8'h02);
        queue_drained <= 2'h1;
        wait_cyc(1);
        queue_drained <= 2'h0;
        wait_cyc(3);
        chk({7'h0, transmitter_off[0]}, 8'h01);
        trig(4'h3);
        chk(n0[7:0], 8'h02);
        // System clock copy on the pin
        wr(1'b0, 1'b0, GCTS_ADDR_SYNC_CTRL, 8'h80);
        wait_cyc(2);
        chk({4'h0, sysclk_to_pin_en, transmitter_off}, 8'h04);
        uart_sysclk <= 2'h1;
        wait_cyc(4);
        chk({7'h0, sysclk_to_pin[0]}, 8'h01);
        uart_sysclk <= 2'h0;
        wait_cyc(4);
        chk({7'h0, sysclk_to_pin[0]}, 8'h00);
        // Delayed start of 258 bit intervals
        wr(1'b0, 1'b0, GCTS_ADDR_SYNC_CTRL, 8'h33);
        trig(4'h3);
        for (int t = 0; t < 258; t++)
        begin
            chk(n0[7:0], 8'h02);
            bit_tick <= 2'h3;
            wait_cyc(1);
            bit_tick <= 2'h0;
            wait_cyc(1);
        end
        wait_cyc(3);
        chk(n0[7:0], 8'h03);
        give_verdict();
    end
endmodule
`default_nettype wire
